// *** logic/tcas_pkg.sv ***
`default_nettype none
package tcas_pkg;
    // ========================================
    // register map
    localparam int            ADDR_W           = 9;
    localparam int            DATA_W           = 8;
    localparam int            ALARM_N          = 6;
    localparam logic [8:0]    ADDR_LATCHED     = 9'h101;
    localparam logic [8:0]    ADDR_ONE_SEC     = 9'h103;
    localparam logic [7:0]    LATCHED_RST      = 8'h00;
    localparam logic [7:0]    ONE_SEC_RST      = 8'h00;
    localparam logic [7:0]    RDATA_RST        = 8'h00;
    // ========================================
    // alarm bit positions, shared by both registers
    localparam int            BIT_LINE_AIS     = 5;
    localparam int            BIT_B_FIFO_ERR   = 4;
    localparam int            BIT_A_FIFO_ERR   = 3;
    localparam int            BIT_UNLOCK       = 2;
    localparam int            BIT_SIGNAL_LOSS  = 1;
    localparam int            BIT_CLOCK_LOSS   = 0;
    // ========================================
    // transition options per alarm
    localparam logic [1:0]    EDGE_RISE        = 2'h1;
    localparam logic [1:0]    EDGE_FALL        = 2'h2;
    localparam logic [1:0]    EDGE_BOTH        = 2'h3;
    // ========================================
    // timing counts
    localparam int            LOC_STUCK_CYCLES = 6;
    localparam int            RECENTER_MF      = 2;
    typedef enum logic [0:0] {
        FS_IDLE = 1'b0,
        FS_HOLD = 1'b1
    } tcas_fifo_st_t;
endpackage : tcas_pkg
`default_nettype wire

// *** logic/tcas_top.sv ***
`default_nettype none
// Contract
// - clock loss after six stuck periods
// - clock loss clears on first edge
// - latched register bit layout, 7-6 unused
// - latched bits set per transition option
// - reading latched register clears it
// - unlock latch survives channel reset, cleared by read and other resets
// - one-second register bit layout
// - second bit: changed or active
// - no one-second update without pulse
// - one-second bits never interrupt
// - interrupt gated by per-alarm mask
// - fifo error recenters, holds two multiframes
module tcas_top #(
    parameter int LOC_N = tcas_pkg::LOC_STUCK_CYCLES,
    parameter int MF_N  = tcas_pkg::RECENTER_MF
) (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic                        software_reset_ctl,
    input  wire logic                        chan_reset,
    input  wire logic                        tx_line_clock_in,
    input  wire logic                        line_ais,
    input  wire logic                        analyzer_unlock,
    input  wire logic                        signal_loss,
    input  wire logic                        a_fifo_slip,
    input  wire logic                        b_fifo_slip,
    input  wire logic                        multiframe_pulse,
    input  wire logic                        one_sec_pulse,
    input  wire logic [2*tcas_pkg::ALARM_N-1:0] edge_sel,
    input  wire logic [tcas_pkg::ALARM_N-1:0]   irq_mask,
    input  wire logic                        cpu_rd,
    input  wire logic [tcas_pkg::ADDR_W-1:0] cpu_addr,
    output logic      [tcas_pkg::DATA_W-1:0] cpu_rdata,
    output logic                             irq,
    output logic                             tx_clock_loss_alarm,
    output logic                             a_fifo_recenter,
    output logic                             b_fifo_recenter
);
    import tcas_pkg::*;

    localparam int CW  = $clog2(LOC_N + 1);
    localparam int MW  = $clog2(MF_N + 1);
    localparam int AN  = ALARM_N;

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        edge_hit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && !prev && cur)
                || ((sel == EDGE_FALL || sel == EDGE_BOTH) && prev && !cur);
    endfunction : edge_hit

    logic rst;
    assign rst = srst || software_reset_ctl;

    // ========================================
    // line clock loss detector
    logic          sync1_q, sync1_d;
    logic          sync2_q, sync2_d;
    logic          sync3_q, sync3_d;
    logic [CW-1:0] loc_cnt_q, loc_cnt_d;
    logic          loss_q, loss_d;
    logic          loc_edge;

    always_comb begin
        sync1_d   = tx_line_clock_in;
        sync2_d   = sync1_q;
        sync3_d   = sync2_q;
        loc_edge  = sync2_q ^ sync3_q;
        loc_cnt_d = loc_cnt_q;
        loss_d    = loss_q;
        if (loc_edge) begin
            loc_cnt_d = '0;
            loss_d    = 1'b0;
        end else if (loc_cnt_q != CW'(LOC_N)) begin
            loc_cnt_d = loc_cnt_q + CW'(1);
            if (loc_cnt_q == CW'(LOC_N - 1)) begin
                loss_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
        sync3_q <= sync3_d;
        if (rst) begin
            loc_cnt_q <= '0;
            loss_q    <= 1'b0;
        end else begin
            loc_cnt_q <= loc_cnt_d;
            loss_q    <= loss_d;
        end
    end

    // ========================================
    // add fifo recentre, one per side
    logic [1:0] slip;
    logic [1:0] hold;
    assign slip = {b_fifo_slip, a_fifo_slip};

    for (genvar s = 0; s < 2; s++) begin : g_side
        tcas_fifo_st_t st_q, st_d;
        logic [MW-1:0] mf_q, mf_d;

        always_comb begin
            st_d = st_q;
            mf_d = mf_q;
            case (st_q)
                FS_IDLE: begin
                    if (slip[s]) begin
                        st_d = FS_HOLD;
                        mf_d = '0;
                    end
                end
                FS_HOLD: begin
                    // a new slip restarts the hold window
                    if (slip[s]) begin
                        mf_d = '0;
                    end else if (multiframe_pulse) begin
                        if (mf_q == MW'(MF_N - 1)) begin
                            st_d = FS_IDLE;
                        end
                        mf_d = mf_q + MW'(1);
                    end
                end
                default: begin
                    st_d = FS_IDLE;
                end
            endcase
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                st_q <= FS_IDLE;
                mf_q <= '0;
            end else begin
                st_q <= st_d;
                mf_q <= mf_d;
            end
        end

        assign hold[s] = (st_q == FS_HOLD);
    end

    // ========================================
    // alarm vector and transition detection
    logic [AN-1:0] alm;
    logic [AN-1:0] alm_prev_q;
    logic [AN-1:0] set_vec;
    logic [AN-1:0] chg_vec;

    always_comb begin
        alm                  = '0;
        alm[BIT_LINE_AIS]    = line_ais;
        alm[BIT_B_FIFO_ERR]  = hold[1];
        alm[BIT_A_FIFO_ERR]  = hold[0];
        alm[BIT_UNLOCK]      = analyzer_unlock;
        alm[BIT_SIGNAL_LOSS] = signal_loss;
        alm[BIT_CLOCK_LOSS]  = loss_q;
        for (int i = 0; i < AN; i++) begin
            set_vec[i] = edge_hit(edge_sel[2*i +: 2], alm_prev_q[i], alm[i]);
        end
        chg_vec = alm ^ alm_prev_q;
    end

    // ========================================
    // latched, one-second and read path
    logic [AN-1:0]     latched_q, latched_d;
    logic [AN-1:0]     chg_q, chg_d;
    logic [AN-1:0]     sec_q, sec_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              irq_q, irq_d;
    logic              rd_latched;
    logic              rd_sec;

    always_comb begin
        rd_latched = cpu_rd && (cpu_addr == ADDR_LATCHED);
        rd_sec     = cpu_rd && (cpu_addr == ADDR_ONE_SEC);
        latched_d  = latched_q;
        if (rd_latched) begin
            latched_d = '0;
        end
        if (chan_reset) begin
            // unlock latch survives the channel reset
            latched_d = latched_d & AN'(1 << BIT_UNLOCK);
        end
        latched_d = latched_d | set_vec;                                 // set wins over read
        chg_d = chg_q | chg_vec;
        sec_d = sec_q;
        if (one_sec_pulse) begin
            sec_d = chg_q | chg_vec | alm;
            chg_d = '0;
        end
        rdata_d = '0;
        if (rd_latched) begin
            rdata_d[AN-1:0] = latched_q;
        end else if (rd_sec) begin
            rdata_d[AN-1:0] = sec_q;
        end
        // only latched bits feed the interrupt
        irq_d = |(latched_q & irq_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alm_prev_q <= '0;
            latched_q  <= LATCHED_RST[AN-1:0];
            chg_q      <= '0;
            sec_q      <= ONE_SEC_RST[AN-1:0];
            rdata_q    <= RDATA_RST;
            irq_q      <= 1'b0;
        end else begin
            alm_prev_q <= alm;
            latched_q  <= latched_d;
            chg_q      <= chg_d;
            sec_q      <= sec_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
        end
    end

    assign cpu_rdata           = rdata_q;
    assign irq                 = irq_q;
    assign tx_clock_loss_alarm = loss_q;
    assign a_fifo_recenter     = hold[0];
    assign b_fifo_recenter     = hold[1];

    // ========================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_loc_raise: assert property (!loc_edge [*6] |=> tx_clock_loss_alarm)
        else $error("clock loss not raised after stuck clock");
    a_loc_clear: assert property (loc_edge |=> !tx_clock_loss_alarm)
        else $error("clock loss not cleared on edge");
    a_sync_path: assert property (loc_edge |-> $past(tx_line_clock_in, 2) != $past(tx_line_clock_in, 3))
        else $error("edge not from synchronised clock");
    a_read_clear: assert property (rd_latched && !chan_reset && set_vec == '0 |=> latched_q == '0)
        else $error("latched register not cleared by read");
    a_edge_set: assert property (set_vec[0] |=> latched_q[0])
        else $error("latched clock loss missed its transition");
    a_unlock_keep: assert property (chan_reset && !rd_latched && latched_q[BIT_UNLOCK]
        |=> latched_q[BIT_UNLOCK])
        else $error("unlock latch cleared by channel reset");
    a_sec_stable: assert property (!one_sec_pulse |=> $stable(sec_q))
        else $error("one-second bits moved without pulse");
    a_sec_active: assert property (one_sec_pulse |=> (sec_q & $past(alm)) == $past(alm))
        else $error("active alarm missing from one-second bits");
    a_irq_mask: assert property (irq |-> ($past(latched_q) & $past(irq_mask)) != '0)
        else $error("interrupt without masked latched alarm");
    a_irq_raise: assert property ((latched_q & irq_mask) != '0 |=> irq)
        else $error("masked latched alarm gave no interrupt");
    a_fifo_hold: assert property (a_fifo_slip |=> a_fifo_recenter [*2])
        else $error("fifo recentre hold missing");
    a_unused_zero: assert property (cpu_rdata[7:6] == 2'h0)
        else $error("unused bits not zero");

    c_loc_loss: cover property (!tx_clock_loss_alarm ##1 tx_clock_loss_alarm);
    c_sec_capture: cover property (one_sec_pulse && chg_q != '0);
    c_irq_fire: cover property (!irq ##1 irq);
    c_fifo_done: cover property (a_fifo_recenter ##1 !a_fifo_recenter);
endmodule : tcas_top
`default_nettype wire

// *** testbench/tcas_line_clk_src.sv ***
`default_nettype none
// ========================================
// line interface model: transmit line clock source
module tcas_line_clk_src (
    input  wire logic run,
    input  wire logic slow,
    input  wire logic stuck_level,
    output var  logic line_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    // half periods stay under six system cycles, else a healthy line reads as lost
    // edges kept on odd nanoseconds, clear of the sampling edge, so no race
    initial begin
        line_clk = 1'b0;
        #3;
        forever begin
            if (run) begin
                #(slow ? 14 : 10);
                line_clk = ~line_clk;
            end else begin
                line_clk = stuck_level;
                @(run);
                #3;
            end
        end
    end
endmodule : tcas_line_clk_src
`default_nettype wire

// *** testbench/tx_channel_alarm_status_tb.sv ***
`default_nettype none
module tx_channel_alarm_status_tb import tcas_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MFN = 2;
    logic        clk_sys = 1'b0, srst = 1'b1, software_reset_ctl = 1'b0, chan_reset = 1'b0;
    logic        line_ais = 1'b0, analyzer_unlock = 1'b0, signal_loss = 1'b0, cpu_rd = 1'b0;
    logic        a_fifo_slip = 1'b0, b_fifo_slip = 1'b0, multiframe_pulse = 1'b0, one_sec_pulse = 1'b0;
    logic        run = 1'b1, slow = 1'b0, stuck = 1'b0;
    logic [11:0] edge_sel = 12'hFFF;
    logic [5:0]  irq_mask = 6'h3F;
    logic [8:0]  cpu_addr = 9'h000;
    logic [7:0]  cpu_rdata;
    logic        irq, tx_clock_loss_alarm, a_fifo_recenter, b_fifo_recenter, tx_line_clock_in;
    bit   [5:0]  lvl, chg, lat, sec;
    int          num_errors, n_tests;
    logic [31:0] rv;

    tcas_top #(.LOC_N(LOC_STUCK_CYCLES), .MF_N(MFN)) u_dut (
        .clk_sys, .srst, .software_reset_ctl, .chan_reset, .tx_line_clock_in, .line_ais,
        .analyzer_unlock, .signal_loss, .a_fifo_slip, .b_fifo_slip, .multiframe_pulse,
        .one_sec_pulse, .edge_sel, .irq_mask, .cpu_rd, .cpu_addr, .cpu_rdata, .irq,
        .tx_clock_loss_alarm, .a_fifo_recenter, .b_fifo_recenter);
    tcas_line_clk_src u_line (.run, .slow, .stuck_level(stuck), .line_clk(tx_line_clock_in));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // ========================================
    // model and helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic set_lvl(input int i, input bit v);
        if (v != lvl[i]) begin
            chg[i] = 1'b1;
            if (edge_sel[2*i + (v ? 0 : 1)]) lat[i] = 1'b1;
            lvl[i] = v;
        end
    endtask : set_lvl
    task automatic apply_lvls();
        set_lvl(5, line_ais);
        set_lvl(2, analyzer_unlock);
        set_lvl(1, signal_loss);
    endtask : apply_lvls
    task automatic rd_chk(input logic [8:0] a);
        logic [7:0] e;
        e = (a == ADDR_LATCHED) ? {2'h0, lat} : (a == ADDR_ONE_SEC) ? {2'h0, sec} : 8'h00;
        cpu_rd = 1'b1;
        cpu_addr = a;
        tick(1);
        chk(cpu_rdata, e);
        cpu_rd = 1'b0;
        if (a == ADDR_LATCHED) lat = 6'h00;
        tick(1);
    endtask : rd_chk
    task automatic chk_lvl();
        logic [7:0] e;
        e = {4'h0, |(lat & irq_mask), lvl[0], lvl[3], lvl[4]};
        chk({4'h0, irq, tx_clock_loss_alarm, a_fifo_recenter, b_fifo_recenter}, e);
    endtask : chk_lvl
    task automatic clk_step(input bit go, input bit lvl_stuck);
        int k;
        stuck = lvl_stuck;
        slow = ~slow;
        run = go;
        k = 0;
        while (tx_clock_loss_alarm !== !go && k < 20) begin
            tick(1);
            k++;
        end
        set_lvl(0, !go);
        if (go) chk({7'h0, k <= 8}, 8'h01);
        else chk({7'h0, k >= 6 && k <= 12}, 8'h01);
    endtask : clk_step
    task automatic mf_pair();
        for (int j = 0; j < MFN; j++) begin
            multiframe_pulse = 1'b1;
            tick(1);
            multiframe_pulse = 1'b0;
            tick(2);
        end
        set_lvl(3, 1'b0);
        set_lvl(4, 1'b0);
    endtask : mf_pair
    task automatic sec_pulse();
        one_sec_pulse = 1'b1;
        tick(1);
        one_sec_pulse = 1'b0;
        sec = chg | lvl;
        chg = 6'h00;
        tick(2);
    endtask : sec_pulse
    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // ========================================
    // stimulus
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(50737));
        tick(6);
        srst = 1'b0;
        tick(2);
        rd_chk(ADDR_LATCHED);
        rd_chk(ADDR_ONE_SEC);
        chk_lvl();
        for (int r = 0; r < 40; r++) begin
            rv = $urandom;
            edge_sel = rv[11:0];
            irq_mask = rv[17:12];
            tick(2);
            {line_ais, analyzer_unlock, signal_loss, a_fifo_slip, b_fifo_slip} = rv[22:18];
            tick(1);
            {a_fifo_slip, b_fifo_slip} = 2'h0;
            apply_lvls();
            if (rv[19]) set_lvl(3, 1'b1);
            if (rv[18]) set_lvl(4, 1'b1);
            if (rv[23] != run) clk_step(rv[23], rv[24]);
            tick(8);
            if (rv[25]) mf_pair();
            tick(3);
            chk_lvl();
            rd_chk(ADDR_LATCHED);
            tick(3);
            chk_lvl();
            if (rv[26]) sec_pulse();
            rd_chk(ADDR_ONE_SEC);
            rd_chk(rv[31:23]);
        end
        edge_sel = 12'hFFF;
        if (!run) clk_step(1'b1, 1'b0);
        mf_pair();
        {line_ais, analyzer_unlock, signal_loss} = 3'h0;
        apply_lvls();
        tick(8);
        rd_chk(ADDR_LATCHED);
        {line_ais, analyzer_unlock} = 2'h3;
        apply_lvls();
        tick(8);
        chan_reset = 1'b1;
        tick(1);
        chan_reset = 1'b0;
        lat = lat & 6'h04;
        tick(2);
        rd_chk(ADDR_LATCHED);
        {line_ais, analyzer_unlock} = 2'h0;
        apply_lvls();
        tick(8);
        software_reset_ctl = 1'b1;
        tick(2);
        software_reset_ctl = 1'b0;
        {lat, sec, chg} = 18'h00000;
        tick(2);
        rd_chk(ADDR_LATCHED);
        rd_chk(ADDR_ONE_SEC);
        rd_chk(9'h102);
        chk_lvl();
        print_verdict();
    end
endmodule : tx_channel_alarm_status_tb
`default_nettype wire
